// *** logic/trim_bank_pkg.sv ***
/*
 * shared constants and carrier types for the trim register bank.
 * assumes a 16-bit word register port driven by the output-pin
 * programming front end; no public bus.
 */
package trim_bank_pkg;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;

    // register indices on the programming port
    localparam logic [3:0] IDX_FACTORY_TRACE_1 = 4'h0;
    localparam logic [3:0] IDX_FACTORY_TRACE_2 = 4'h1;
    localparam logic [3:0] IDX_USER_TRACE_1 = 4'h2;
    localparam logic [3:0] IDX_USER_TRACE_2 = 4'h3;
    localparam logic [3:0] IDX_RATIO_OFFSET = 4'h4;
    localparam logic [3:0] IDX_FIXED_OFFSET = 4'h5;
    localparam logic [3:0] IDX_QUADRATURE = 4'h6;
    localparam logic [3:0] IDX_FIELD_SPAN = 4'h7;
    localparam logic [3:0] IDX_AMPLITUDE = 4'h8;
    localparam logic [3:0] IDX_CONFIG = 4'h9;
    localparam logic [3:0] IDX_OUTPUT_DRIVER = 4'hA;
    localparam logic [3:0] IDX_SUPPLY_REG = 4'hB;
    localparam logic [3:0] IDX_OFFSET_ENABLE = 4'hC;

    // writable-bit masks; unassigned positions read zero
    localparam logic [15:0] MASK_RATIO_OFFSET = 16'h3F3F;
    localparam logic [15:0] MASK_FIXED_OFFSET = 16'hFFFF;
    localparam logic [15:0] MASK_QUADRATURE = 16'hFFFF;
    localparam logic [15:0] MASK_AMPLITUDE = 16'h3F3F;
    localparam logic [15:0] MASK_FULL = 16'hFFFF;
    localparam logic [15:0] MASK_OFFSET_ENABLE = 16'h0001;

    localparam logic [15:0] RESET_WORD = 16'h0000;

    // field positions
    localparam int TRIM_SEL_BIT = 10;
    localparam int OFFSET_EN_BIT = 0;
    localparam int SPAN_LSB = 11;
    localparam int SPAN_W = 5;
    localparam logic [4:0] SPAN_SMALLEST = 5'h1D;  // 5 mT
    localparam logic [4:0] SPAN_LARGEST = 5'h00;   // 250 mT

    // all channel fields of one trim set: signed-magnitude pairs and gain codes
    typedef struct packed {
        logic ratio_neg_a;
        logic [4:0] ratio_mag_a;
        logic ratio_neg_b;
        logic [4:0] ratio_mag_b;
        logic fixed_neg_a;
        logic [6:0] fixed_mag_a;
        logic fixed_neg_b;
        logic [6:0] fixed_mag_b;
        logic quad_neg_a;
        logic [6:0] quad_mag_a;
        logic quad_neg_b;
        logic [6:0] quad_mag_b;
        logic [5:0] amp_code_a;
        logic [5:0] amp_code_b;
    } trim_set_t;

    // programming-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } prog_req_t;

endpackage

// *** logic/trim_word_unpack.sv ***
/*
 * splits four raw trim words into the channel fields of a trim set.
 * assumes the words are already masked; purely combinational.
 */
`timescale 1ns/100ps
module trim_word_unpack
    import trim_bank_pkg::*;
(
    input wire logic [15:0] ratio_word,
    input wire logic [15:0] fixed_word,
    input wire logic [15:0] quad_word,
    input wire logic [15:0] amp_word,
    output trim_set_t fields
);

    // ***************************************************
    // field extraction
    // ***************************************************
    // signed-magnitude pairs and gain codes, channel a low byte, b high byte
    always_comb
    begin
        fields.ratio_mag_a = ratio_word[4:0];
        fields.ratio_neg_a = ratio_word[5];
        fields.ratio_mag_b = ratio_word[12:8];
        fields.ratio_neg_b = ratio_word[13];
        fields.fixed_mag_a = fixed_word[6:0];
        fields.fixed_neg_a = fixed_word[7];
        fields.fixed_mag_b = fixed_word[14:8];
        fields.fixed_neg_b = fixed_word[15];
        fields.quad_mag_a = quad_word[6:0];
        fields.quad_neg_a = quad_word[7];
        fields.quad_mag_b = quad_word[14:8];
        fields.quad_neg_b = quad_word[15];
        fields.amp_code_a = amp_word[5:0];
        fields.amp_code_b = amp_word[13:8];
    end

endmodule // trim_word_unpack

// *** logic/trim_shadow_copy.sv ***
/*
 * signal-path shadow registers for one trim set.
 * assumes load is a one-cycle pulse on clk; rst is async active high.
 */
`timescale 1ns/100ps
module trim_shadow_copy
    import trim_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input trim_set_t source,
    output trim_set_t shadow
);

    trim_set_t shadow_ff;
    trim_set_t nxt_shadow;

    // ***************************************************
    // shadow copy
    // ***************************************************
    // holds the applied set so the path only changes on a load pulse
    always_comb
    begin
        nxt_shadow = shadow_ff;
        if (load)
        begin
            nxt_shadow = source;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shadow_ff <= '0;
        end
        else
        begin
            shadow_ff <= nxt_shadow;
        end
    end

    assign shadow = shadow_ff;

endmodule // trim_shadow_copy

// *** logic/sensor_trim_register_bank.sv ***
/*
 * register bank for the angle sensor trim words, trace words and
 * configuration words, with trim-set selection into shadow registers.
 * assumes a word-wide programming port from the output-pin decoder on
 * the same clock, and factory words supplied from nonvolatile storage.
 */
// What this block does
// - two read-only 16-bit factory trace words
// - two writable 16-bit user trace words
// - select 0 factory trim, 1 user trim
// - select bit 10 of configuration word
// - ratio offset fields, sign-magnitude, 5-bit
// - offsets shift each channel pair differentially
// - fixed offset fields, sign-magnitude, 7-bit
// - fixed offset applied only when enabled
// - quadrature fields, zero means no correction
// - quadrature step 0.11 degrees, range 14
// - positive phase rotates counterclockwise
// - coarse span code in bits 15:11
// - amplitude codes 6-bit, channels a, b
// - fine gain 15 over 12-2code/63
// - configuration words are 16-bit registers
`timescale 1ns/100ps
module sensor_trim_register_bank
    import trim_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input prog_req_t prog_req,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_addr_err,
    input wire logic [15:0] factory_trace_word_1,
    input wire logic [15:0] factory_trace_word_2,
    input trim_set_t factory_trim,
    input wire logic start_copy,
    output trim_set_t applied_trim,
    output logic fixed_offset_active,
    output logic [4:0] field_span_code,
    output logic [15:0] config_word,
    output logic [15:0] output_driver_setup,
    output logic [15:0] supply_regulation_setup,
    output logic [15:0] field_span_and_bandwidth
);

    localparam int NUM_RW = 11;

    // ***************************************************
    // storage slot map
    // ***************************************************
    // the package fixes the port index of each word; these fix where
    // the word sits in word_ff, so the slot numbers never leak out
    // into the port map and the two can be reordered independently
    localparam int SLOT_NONE = -1; // read-only or unmapped index
    localparam int SLOT_USER_TRACE_1 = 0;
    localparam int SLOT_USER_TRACE_2 = 1;
    localparam int SLOT_RATIO_OFFSET = 2;
    localparam int SLOT_FIXED_OFFSET = 3;
    localparam int SLOT_QUADRATURE = 4;
    localparam int SLOT_FIELD_SPAN = 5;
    localparam int SLOT_AMPLITUDE = 6;
    localparam int SLOT_CONFIG = 7;
    localparam int SLOT_OUTPUT_DRIVER = 8;
    localparam int SLOT_SUPPLY_REG = 9;
    localparam int SLOT_OFFSET_ENABLE = 10;
    // the trim words sit in one run of slots, with the field span word
    // inside it at slot 5, so that a single range test tells whether a
    // write must refresh the shadow copy; keep them together if the map is ever extended
    localparam int SLOT_TRIM_FIRST = SLOT_RATIO_OFFSET;
    localparam int SLOT_TRIM_LAST = SLOT_AMPLITUDE;

    // ***************************************************
    // writable word storage
    // ***************************************************
    logic [15:0] word_ff [NUM_RW];
    logic [15:0] nxt_word [NUM_RW];
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic err_ff;
    logic nxt_err;
    logic load_ff;
    logic nxt_load;
    logic sel_prev_ff;
    logic nxt_sel_prev;
    trim_set_t user_trim;
    trim_set_t chosen_trim;
    trim_set_t shadow_out;

    // maps a port index to a storage slot, or -1 when not writable
    function automatic int slot_of(input logic [3:0] addr);
        int s;
        s = SLOT_NONE;
        // factory trace indices fall to the default on purpose: they
        // have no slot, which is what makes them refuse writes
        case (addr)
            IDX_USER_TRACE_1: s = SLOT_USER_TRACE_1;
            IDX_USER_TRACE_2: s = SLOT_USER_TRACE_2;
            IDX_RATIO_OFFSET: s = SLOT_RATIO_OFFSET;
            IDX_FIXED_OFFSET: s = SLOT_FIXED_OFFSET;
            IDX_QUADRATURE: s = SLOT_QUADRATURE;
            IDX_FIELD_SPAN: s = SLOT_FIELD_SPAN;
            IDX_AMPLITUDE: s = SLOT_AMPLITUDE;
            IDX_CONFIG: s = SLOT_CONFIG;
            IDX_OUTPUT_DRIVER: s = SLOT_OUTPUT_DRIVER;
            IDX_SUPPLY_REG: s = SLOT_SUPPLY_REG;
            IDX_OFFSET_ENABLE: s = SLOT_OFFSET_ENABLE;
            default: s = SLOT_NONE;
        endcase
        return s;
    endfunction

    // writable-bit mask per slot; the rest is held at zero
    function automatic logic [15:0] mask_of(input int s);
        logic [15:0] m;
        m = MASK_FULL;
        case (s)
            SLOT_RATIO_OFFSET: m = MASK_RATIO_OFFSET;
            SLOT_FIXED_OFFSET: m = MASK_FIXED_OFFSET;
            SLOT_QUADRATURE: m = MASK_QUADRATURE;
            SLOT_AMPLITUDE: m = MASK_AMPLITUDE;
            SLOT_OFFSET_ENABLE: m = MASK_OFFSET_ENABLE;
            default: m = MASK_FULL;
        endcase
        return m;
    endfunction

    // word writes; masking at write time keeps reads and use in step
    always_comb
    begin
        int ws;
        ws = slot_of(prog_req.addr);
        for (int i = 0; i < NUM_RW; i++)
        begin
            nxt_word[i] = word_ff[i];
        end
        if (prog_req.wr && ws >= 0)
        begin
            nxt_word[ws] = prog_req.wdata & mask_of(ws);
        end
    end

    generate
        for (genvar g = 0; g < NUM_RW; g++)
        begin : g_word
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    word_ff[g] <= RESET_WORD;
                end
                else
                begin
                    word_ff[g] <= nxt_word[g];
                end
            end
        end
    endgenerate

    // ***************************************************
    // read port
    // ***************************************************
    // factory words come straight from storage and cannot be written
    always_comb
    begin
        int rs;
        rs = slot_of(prog_req.addr);
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_err = 1'b0;
        if (prog_req.rd)
        begin
            nxt_rvalid = 1'b1;
            if (prog_req.addr == IDX_FACTORY_TRACE_1)
            begin
                nxt_rdata = factory_trace_word_1;
            end
            else if (prog_req.addr == IDX_FACTORY_TRACE_2)
            begin
                nxt_rdata = factory_trace_word_2;
            end
            else if (rs >= 0)
            begin
                nxt_rdata = word_ff[rs];
            end
            else
            begin
                nxt_rdata = RESET_WORD;
                nxt_err = 1'b1;
            end
        end
        else if (prog_req.wr && slot_of(prog_req.addr) < 0)
        begin
            nxt_err = 1'b1; // read-only or unmapped write dropped
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= RESET_WORD;
            rvalid_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            err_ff <= nxt_err;
        end
    end

    assign prog_rdata = rdata_ff;
    assign prog_rvalid = rvalid_ff;
    assign prog_addr_err = err_ff;

    // ***************************************************
    // trim selection and shadow load
    // ***************************************************
    // the unpacker sees the stored words, already masked, so spare
    // bits cannot reach the signal path even before a reload
    trim_word_unpack u_unpack (
        .ratio_word(word_ff[SLOT_RATIO_OFFSET]),
        .fixed_word(word_ff[SLOT_FIXED_OFFSET]),
        .quad_word(word_ff[SLOT_QUADRATURE]),
        .amp_word(word_ff[SLOT_AMPLITUDE]),
        .fields(user_trim)
    );

    // select bit picks the set; reload on start-up, select change,
    // or any trim write so the path follows the programmer
    always_comb
    begin
        chosen_trim = word_ff[SLOT_CONFIG][TRIM_SEL_BIT]
                      ? user_trim : factory_trim;
        nxt_sel_prev = word_ff[SLOT_CONFIG][TRIM_SEL_BIT];
        // a write lands on the same edge that raises the load pulse, so the
        // copy on the next edge always takes the new word and never the one it replaced
        nxt_load = start_copy
                   || (sel_prev_ff != word_ff[SLOT_CONFIG][TRIM_SEL_BIT])
                   || (prog_req.wr
                       && (slot_of(prog_req.addr) >= SLOT_TRIM_FIRST)
                       && (slot_of(prog_req.addr) <= SLOT_TRIM_LAST));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            load_ff <= 1'b1;
            sel_prev_ff <= 1'b0;
        end
        else
        begin
            load_ff <= nxt_load;
            sel_prev_ff <= nxt_sel_prev;
        end
    end

    // each channel's sign-magnitude value moves its pin pair together
    trim_shadow_copy u_shadow (
        .clk(clk),
        .rst(rst),
        .load(load_ff),
        .source(chosen_trim),
        .shadow(shadow_out)
    );

    // offset pairs, quadrature signs and gain codes reach the analog
    // path unchanged; the analog side scales them per step
    assign applied_trim = shadow_out;
    // the enable gates the fixed offset in the analog path; the
    // fields themselves stay in the shadow so toggling the enable
    // needs no reload and cannot glitch the other corrections
    assign fixed_offset_active =
        word_ff[SLOT_OFFSET_ENABLE][OFFSET_EN_BIT];
    assign field_span_code =
        word_ff[SLOT_FIELD_SPAN][SPAN_LSB +: SPAN_W];
    // configuration words go out whole; their fields are decoded by
    // the blocks that own the functions they switch
    assign config_word = word_ff[SLOT_CONFIG];
    assign output_driver_setup = word_ff[SLOT_OUTPUT_DRIVER];
    assign supply_regulation_setup = word_ff[SLOT_SUPPLY_REG];
    assign field_span_and_bandwidth = word_ff[SLOT_FIELD_SPAN];

endmodule // sensor_trim_register_bank

// *** dv/trim_bank_assertions.sv ***
/* port checker for the trim register bank.
   assumes the one clock and async high reset of the bank. */
`timescale 1ns/100ps
module trim_bank_checker
    import trim_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input prog_req_t prog_req,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_rvalid,
    input wire logic prog_addr_err,
    input wire logic [15:0] factory_trace_word_1,
    input trim_set_t factory_trim,
    input wire logic start_copy,
    input trim_set_t applied_trim,
    input wire logic fixed_offset_active,
    input wire logic [4:0] field_span_code,
    input wire logic [15:0] config_word,
    input wire logic [15:0] field_span_and_bandwidth
);
// ****
// properties
// ****
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
a_read_answer: assert property (
    prog_req.rd && prog_req.addr <= 4'hC |=> prog_rvalid)
    else $error("mapped read not answered");
a_rvalid_cause: assert property (
    prog_rvalid |-> $past(prog_req.rd)) else $error("stray read answer");
a_factory_read: assert property (
    prog_req.rd && prog_req.addr == IDX_FACTORY_TRACE_1
    |=> prog_rdata == $past(factory_trace_word_1))
    else $error("factory word misread");
a_ro_write_err: assert property (
    prog_req.wr && !prog_req.rd && prog_req.addr < 4'h2
    |=> prog_addr_err) else $error("read-only write accepted");
a_spare_bits: assert property (
    prog_req.rd && (prog_req.addr == 4'h4 || prog_req.addr == 4'h8)
    |=> (prog_rdata & 16'hC0C0) == 16'h0000) else $error("spare bits set");
a_span_field: assert property (
    field_span_code == field_span_and_bandwidth[15:11])
    else $error("span code misplaced");
a_enable_write: assert property (
    prog_req.wr && !prog_req.rd && prog_req.addr == IDX_OFFSET_ENABLE
    |=> fixed_offset_active == $past(prog_req.wdata[0]))
    else $error("offset enable wrong");
a_config_write: assert property (
    prog_req.wr && !prog_req.rd && prog_req.addr == IDX_CONFIG
    |=> config_word == $past(prog_req.wdata)) else $error("config lost");
// the bench holds factory trim steady across a copy
a_factory_copy: assert property (
    start_copy && !config_word[TRIM_SEL_BIT]
    |-> ##2 applied_trim == factory_trim) else $error("factory copy wrong");
c_err: cover property (prog_addr_err);
c_read: cover property (prog_rvalid);
c_copy: cover property (start_copy);
endmodule // trim_bank_checker
bind sensor_trim_register_bank trim_bank_checker chk (.*);

// *** dv/trim_programmer.sv ***
/* programmer model on the output-pin register port.
   assumes a one-cycle request answered on the following edge. */
`timescale 1ns/100ps
module trim_programmer
    import trim_bank_pkg::*;
(
    input wire logic clk,
    output prog_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic err
);
    initial req = '{1'b0, 1'b0, 4'h0, 16'h0000};
    // one access; released address and data lines show inverted values, not stale ones
    task automatic access(input logic w, input logic [3:0] a,
        input logic [15:0] d, output logic [16:0] ans, output logic e);
        @(negedge clk);
        req = '{w, ~w, a, d};
        @(negedge clk);
        ans = {rvalid, rdata};
        e = err;
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule // trim_programmer

// *** dv/sensor_trim_register_bank_bench.sv ***
/* self-checking bench for the trim register bank.
   assumes the programmer model drives the register port. */
`timescale 1ns/100ps
module sensor_trim_register_bank_bench
    import trim_bank_pkg::*;
;
// ****
// stimulus and checks
// ****
logic clk, rst, start_copy, e, prog_rvalid, prog_addr_err, fixed_offset_active;
logic [15:0] ft1, ft2, prog_rdata, config_word, field_span_and_bandwidth;
logic [15:0] drv_setup, sup_setup;
logic [16:0] ans;
logic [4:0] field_span_code;
prog_req_t req;
trim_set_t fac, applied_trim;
int fail_count = 0, num_checks = 0, cycles = 0;
logic [3:0] r_addr [11] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
    4'h9, 4'hA, 4'hB, 4'hC};
logic [15:0] r_wd [11] = '{16'h1234, 16'hABCD, 16'hFFFF, 16'hFFFF,
    16'h8081, 16'hE800, 16'hFFFF, 16'h0400, 16'h5A5A, 16'hA5A5, 16'hFFFF};
logic [15:0] r_exp [11] = '{16'h1234, 16'hABCD, 16'h3F3F, 16'hFFFF,
    16'h8081, 16'hE800, 16'h3F3F, 16'h0400, 16'h5A5A, 16'hA5A5, 16'h0001};
localparam logic [55:0] USR = {6'h3F, 6'h3F, 8'hFF, 8'hFF, 8'h81, 8'h80,
    6'h3F, 6'h3F};
sensor_trim_register_bank dut (.clk(clk), .rst(rst), .prog_req(req),
    .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
    .prog_addr_err(prog_addr_err), .factory_trace_word_1(ft1),
    .factory_trace_word_2(ft2), .factory_trim(fac),
    .start_copy(start_copy), .applied_trim(applied_trim),
    .fixed_offset_active(fixed_offset_active),
    .field_span_code(field_span_code), .config_word(config_word),
    .output_driver_setup(drv_setup), .supply_regulation_setup(sup_setup),
    .field_span_and_bandwidth(field_span_and_bandwidth));
trim_programmer p (.clk(clk), .req(req), .rdata(prog_rdata),
    .rvalid(prog_rvalid), .err(prog_addr_err));
task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic complete_run();
    if (fail_count == 0 && num_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
initial
begin
    clk = 0;
    forever #25 clk = ~clk;
end
// hang guard, far above the hundred or so cycles the run needs
always @(posedge clk)
begin
    cycles++;
    if (cycles == 5000)
    begin
        fail_count++;
        complete_run();
    end
end
initial
begin
    rst = 1;
    start_copy = 0;
    ft1 = 16'h1357;
    ft2 = 16'h2468;
    fac = trim_set_t'({7{8'hA5}});
    repeat (20) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    check("reset copy", applied_trim, fac);
    check("enable reset", fixed_offset_active, 1'b0);
    // write each writable word, then read it back
    for (int i = 0; i < 11; i++)
    begin
        p.access(1'b1, r_addr[i], r_wd[i], ans, e);
        p.access(1'b0, r_addr[i], 16'h0000, ans, e);
        check("readback", ans, {1'b1, r_exp[i]});
    end
    repeat (2) @(negedge clk);
    check("user trim", applied_trim, USR);
    check("span code", field_span_code, SPAN_SMALLEST);
    check("enable set", fixed_offset_active, 1'b1);
    check("config word", config_word, 16'h0400);
    check("span word", field_span_and_bandwidth, 16'hE800);
    check("driver setup", drv_setup, 16'h5A5A);
    check("supply setup", sup_setup, 16'hA5A5);
    p.access(1'b1, IDX_FACTORY_TRACE_1, 16'hFFFF, ans, e);
    check("ro write", e, 1'b1);
    p.access(1'b0, IDX_FACTORY_TRACE_1, 16'h0000, ans, e);
    check("trace 1", ans, {1'b1, ft1});
    p.access(1'b0, IDX_FACTORY_TRACE_2, 16'h0000, ans, e);
    check("trace 2", ans, {1'b1, ft2});
    p.access(1'b0, 4'hD, 16'h0000, ans, e);
    check("unmapped", e, 1'b1);
    p.access(1'b1, IDX_CONFIG, 16'h0000, ans, e);
    repeat (2) @(negedge clk);
    check("factory trim", applied_trim, fac);
    fac = trim_set_t'(~fac);
    start_copy = 1;
    @(negedge clk);
    start_copy = 0;
    repeat (2) @(negedge clk);
    check("recopy", applied_trim, fac);
    p.access(1'b1, IDX_OFFSET_ENABLE, 16'h0000, ans, e);
    check("enable off", fixed_offset_active, 1'b0);
    complete_run();
end
endmodule // sensor_trim_register_bank_bench
